// ===== spi_clkstop_pkg.sv
// Purpose: shared constants and types for the clock-stop serial port
// Assumes: one 40 MHz processor clock; one processor cycle is the 2P unit
// Notes:   word length is fixed here; the divider width matches the control port
package spi_clkstop_pkg;

  localparam int WORD_BITS   = 8;
  localparam int BITCNT_W    = 4;
  localparam int DIV_W       = 8;
  localparam int TICKCNT_W   = 5;

  // clock-stop mode codes on clockStopMode
  localparam logic [1:0] STOP_NO_DELAY   = 2'h2;
  localparam logic [1:0] STOP_HALF_DELAY = 2'h3;

  // slave operation runs the sample-rate clock at half the processor clock
  localparam logic             SLAVE_SRC_SEL = 1'b1;
  localparam logic [DIV_W-1:0] SLAVE_DIVIDER = 8'h01;

  // shortest phase the divider can make, in processor cycles
  localparam logic [DIV_W-1:0] PHASE_MIN = 8'h01;

  // master frame phases, counted in divider phase ticks
  localparam logic [TICKCNT_W-1:0] LEAD_TICKS_FULL  = 5'h02;
  localparam logic [TICKCNT_W-1:0] LEAD_TICKS_IDLE  = 5'h01;
  localparam logic [TICKCNT_W-1:0] SHIFT_TICKS      = 5'h10;
  localparam logic [TICKCNT_W-1:0] TRAIL_TICKS_FULL = 5'h01;
  localparam logic [TICKCNT_W-1:0] TICK_ONE         = 5'h01;

  localparam logic [BITCNT_W-1:0] BITS_FULL = 4'h8;
  localparam logic [BITCNT_W-1:0] BIT_ONE   = 4'h1;

  // pin synchroniser lanes
  localparam int PIN_SCLK  = 0;
  localparam int PIN_TXFS  = 1;
  localparam int PIN_RXFS  = 2;
  localparam int PIN_RXD   = 3;
  localparam int PIN_COUNT = 4;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_LEAD,
    MS_SHIFT,
    MS_TRAIL
  } master_state_t;

endpackage

// ===== rate_divider.sv
// Purpose: sample-rate clock divider producing phase-end enable pulses
// Assumes: divider value is stable while run is high
// Notes:   a zero divider cannot give a one-cycle period, so it gives two
`timescale 1ns/100ps
module rate_divider (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic                              run,
  input  wire logic                              startLevel,
  input  wire logic [spi_clkstop_pkg::DIV_W-1:0] divider,
  output logic                                   tick,
  output logic                                   level
);

  logic [spi_clkstop_pkg::DIV_W-1:0] cnt_r;
  logic                              level_r;
  wire                               evenDiv;
  wire  [spi_clkstop_pkg::DIV_W-1:0] halfDiv;
  wire  [spi_clkstop_pkg::DIV_W-1:0] halfLen;
  wire  [spi_clkstop_pkg::DIV_W-1:0] lowLen;
  wire  [spi_clkstop_pkg::DIV_W-1:0] highLen;
  wire  [spi_clkstop_pkg::DIV_W-1:0] rawLen;
  wire  [spi_clkstop_pkg::DIV_W-1:0] curLen;

  ////////////////////////////////////////////////////////////////////////////
  // phase lengths
  assign evenDiv = ~divider[0] & (|divider);
  assign halfDiv = divider >> 1;
  assign halfLen = halfDiv + {{(spi_clkstop_pkg::DIV_W-1){1'b0}}, divider[0]};
  assign lowLen  = evenDiv ? halfDiv : halfLen;
  assign highLen = evenDiv ? halfDiv + spi_clkstop_pkg::PHASE_MIN : halfLen;
  assign rawLen  = level_r ? highLen : lowLen;
  assign curLen  = (rawLen == '0) ? spi_clkstop_pkg::PHASE_MIN : rawLen;
  // period is (1 + divider) processor cycles, two cycles for a zero divider
  assign tick    = run & (cnt_r == curLen - spi_clkstop_pkg::PHASE_MIN);
  assign level   = level_r;

  ////////////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else if (!run) begin
      cnt_r   <= '0;
      level_r <= startLevel;
    end else if (tick) begin
      cnt_r   <= '0;
      level_r <= ~level_r;
    end else begin
      cnt_r   <= cnt_r + spi_clkstop_pkg::PHASE_MIN;
    end
  end

endmodule // rate_divider

// ===== serial_port_spi_clock_stop.sv
// Purpose: clock-stop (SPI) mode of a buffered serial port, master or slave
// Assumes: control inputs are static while a frame is in flight
// Notes:   words are sent and received msb first, one word per frame
//
// Notes on behaviour
// - slave runs rate clock at half processor clock
// - master clock period is one plus divider cycles, two cycles at divider zero
// - even divider gives longer high than low phase
// - master inverts frame output into active-low enable
// - slave inverts active-low frame inputs before use
// - master drives clock and frame, receive directions in
// - slave takes clock and frames from outside
// - enable asserted before the first clock edge
// - mode 11 lead full period, trail one idle phase
// - mode 10 lead idle phase, trail full period
// - mode 10 polarity 1 samples rising, shifts falling
// - mode 10 slave releases data when enable rises
// - mode 11 releases data at edge after last bit
`timescale 1ns/100ps
module serial_port_spi_clock_stop (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic [1:0]                            clockStopMode,
  input  wire logic                                  txClockPolarity,
  input  wire logic                                  rateClockSourceSel,
  input  wire logic [spi_clkstop_pkg::DIV_W-1:0]     rateClockDivider,
  input  wire logic                                  rxFramePolarity,
  input  wire logic                                  txFramePolarity,
  input  wire logic                                  txClockDirection,
  input  wire logic                                  txFrameDirection,
  input  wire logic                                  rxClockDirection,
  input  wire logic                                  rxFrameDirection,
  input  wire logic [spi_clkstop_pkg::WORD_BITS-1:0] txData,
  input  wire logic                                  txValid,
  output logic                                       txReady,
  output logic [spi_clkstop_pkg::WORD_BITS-1:0]      rxData,
  output logic                                       rxValid,
  output logic                                       busy,
  output logic                                       configError,
  input  wire logic                                  txSerialClockPinIn,
  output logic                                       txSerialClockPinOut,
  output logic                                       txSerialClockPinOe,
  input  wire logic                                  txFrameSyncPinIn,
  output logic                                       txFrameSyncPinOut,
  output logic                                       txFrameSyncPinOe,
  input  wire logic                                  rxFrameSyncPinIn,
  input  wire logic                                  rxSerialDataPinIn,
  output logic                                       txSerialDataPinOut,
  output logic                                       txSerialDataPinOe
);

  localparam int WB = spi_clkstop_pkg::WORD_BITS;
  localparam int PC = spi_clkstop_pkg::PIN_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  spi_clkstop_pkg::master_state_t     state_r;
  spi_clkstop_pkg::master_state_t     state_nxt;
  logic [spi_clkstop_pkg::TICKCNT_W-1:0] tickCnt_r;
  logic [spi_clkstop_pkg::TICKCNT_W-1:0] tickCnt_nxt;
  logic [PC-1:0]                      pinSync1_r;
  logic [PC-1:0]                      pinSync2_r;
  logic [PC-1:0]                      pinSync3_r;
  logic [PC-1:0]                      pinFilt_r;
  logic                               slvClk_r;
  logic                               slvTxFrame_r;
  logic                               slvRxFrame_r;
  logic                               frameOn_r;
  logic [WB-1:0]                      txHold_r;
  logic                               txHoldFull_r;
  logic [WB-1:0]                      txShift_r;
  logic [WB-1:0]                      rxShift_r;
  logic [spi_clkstop_pkg::BITCNT_W-1:0] bitCnt_r;
  logic                               pendShift_r;
  logic                               txDone_r;
  logic [WB-1:0]                      rxData_r;
  logic                               rxValid_r;
  logic                               configError_r;
  logic                               divTick;
  logic                               divLevel;

  wire                                stopOn;
  wire                                halfDelay;
  wire                                masterCfg;
  wire                                slaveCfg;
  wire                                masterMode;
  wire                                slaveMode;
  wire                                idleLevel;
  wire                                activeLevel;
  wire [spi_clkstop_pkg::DIV_W-1:0]   divUsed;
  wire                                divRun;
  wire                                divStart;
  wire                                masterFrame;
  wire                                masterStart;
  wire [spi_clkstop_pkg::TICKCNT_W-1:0] leadTicks;
  wire                                lastTick;
  wire                                mActEdge;
  wire                                mIdleEdge;
  wire                                rateStrobe;
  wire                                slvClkRise;
  wire                                slvClkChange;
  wire                                sActEdge;
  wire                                sIdleEdge;
  wire                                txFrameInt;
  wire                                rxFrameInt;
  wire                                frameOn;
  wire                                frameStart;
  wire                                frameEnd;
  wire                                rxFrameOk;
  wire                                activeEdge;
  wire                                idleEdge;
  wire                                sampleEdge;
  wire                                changeEdge;
  wire                                bitsFull;
  wire                                rxBit;
  wire                                holdTake;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign stopOn      = (clockStopMode == spi_clkstop_pkg::STOP_NO_DELAY) |
                       (clockStopMode == spi_clkstop_pkg::STOP_HALF_DELAY);
  assign halfDelay   = (clockStopMode == spi_clkstop_pkg::STOP_HALF_DELAY);
  assign masterCfg   = txClockDirection & txFrameDirection &
                       ~rxClockDirection & ~rxFrameDirection;
  assign slaveCfg    = ~txClockDirection & ~txFrameDirection &
                       ~rxClockDirection & ~rxFrameDirection;
  assign masterMode  = stopOn & masterCfg;
  // a slave needs the internal half-rate sample clock to keep its edge timing
  assign slaveMode   = stopOn & slaveCfg &
                       (rateClockSourceSel == spi_clkstop_pkg::SLAVE_SRC_SEL);
  assign idleLevel   = txClockPolarity;
  assign activeLevel = ~txClockPolarity;

  ////////////////////////////////////////////////////////////////////////////
  // sample-rate clock
  assign divUsed  = slaveMode ? spi_clkstop_pkg::SLAVE_DIVIDER : rateClockDivider;
  assign divRun   = slaveMode | (masterMode & (state_r != spi_clkstop_pkg::MS_IDLE));
  // mode 11 opens with an active-length phase so the first edge lands at one period
  assign divStart = slaveMode ? 1'b0 : (halfDelay ? activeLevel : idleLevel);

  rate_divider u_rate_divider (
    .clk        (clk),
    .rstn       (rstn),
    .run        (divRun),
    .startLevel (divStart),
    .divider    (divUsed),
    .tick       (divTick),
    .level      (divLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // master frame sequencing
  assign masterStart = masterMode & txHoldFull_r & ~frameOn_r;
  assign leadTicks   = halfDelay ? spi_clkstop_pkg::LEAD_TICKS_FULL
                                 : spi_clkstop_pkg::LEAD_TICKS_IDLE;
  assign lastTick    = divTick & (tickCnt_r == leadTicks - spi_clkstop_pkg::TICK_ONE);

  always_comb begin
    state_nxt   = state_r;
    tickCnt_nxt = tickCnt_r;
    case (state_r)
      spi_clkstop_pkg::MS_IDLE: begin
        tickCnt_nxt = '0;
        if (masterStart) begin
          state_nxt = spi_clkstop_pkg::MS_LEAD;
        end
      end
      spi_clkstop_pkg::MS_LEAD: begin
        if (divTick) begin
          tickCnt_nxt = tickCnt_r + spi_clkstop_pkg::TICK_ONE;
        end
        if (lastTick) begin
          tickCnt_nxt = '0;
          state_nxt   = spi_clkstop_pkg::MS_SHIFT;
        end
      end
      spi_clkstop_pkg::MS_SHIFT: begin
        if (divTick) begin
          tickCnt_nxt = tickCnt_r + spi_clkstop_pkg::TICK_ONE;
          if (tickCnt_r == spi_clkstop_pkg::SHIFT_TICKS - spi_clkstop_pkg::TICK_ONE) begin
            tickCnt_nxt = '0;
            // mode 11 ends with the last idle phase, mode 10 adds a phase
            state_nxt   = halfDelay ? spi_clkstop_pkg::MS_IDLE
                                    : spi_clkstop_pkg::MS_TRAIL;
          end
        end
      end
      spi_clkstop_pkg::MS_TRAIL: begin
        if (divTick) begin
          tickCnt_nxt = tickCnt_r + spi_clkstop_pkg::TICK_ONE;
          if (tickCnt_r == spi_clkstop_pkg::TRAIL_TICKS_FULL - spi_clkstop_pkg::TICK_ONE) begin
            tickCnt_nxt = '0;
            state_nxt   = spi_clkstop_pkg::MS_IDLE;
          end
        end
      end
      default: begin
        state_nxt   = spi_clkstop_pkg::MS_IDLE;
        tickCnt_nxt = '0;
      end
    endcase
    if (!masterMode) begin
      state_nxt   = spi_clkstop_pkg::MS_IDLE;
      tickCnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= spi_clkstop_pkg::MS_IDLE;
      tickCnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      tickCnt_r <= tickCnt_nxt;
    end
  end

  assign masterFrame = (state_r != spi_clkstop_pkg::MS_IDLE);
  assign mActEdge  = (state_r == spi_clkstop_pkg::MS_LEAD) & lastTick |
                     (state_r == spi_clkstop_pkg::MS_SHIFT) & divTick &
                     (divLevel == idleLevel) &
                     (tickCnt_r != spi_clkstop_pkg::SHIFT_TICKS - spi_clkstop_pkg::TICK_ONE);
  assign mIdleEdge = (state_r == spi_clkstop_pkg::MS_SHIFT) & divTick &
                     (divLevel == activeLevel);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinSync1_r <= '0;
      pinSync2_r <= '0;
      pinSync3_r <= '0;
      pinFilt_r  <= '0;
    end else begin
      pinSync1_r <= {rxSerialDataPinIn, rxFrameSyncPinIn, txFrameSyncPinIn, txSerialClockPinIn};
      pinSync2_r <= pinSync1_r;
      pinSync3_r <= pinSync2_r;
      pinFilt_r  <= (pinSync2_r & pinSync3_r) | (pinFilt_r & (pinSync2_r | pinSync3_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave edge and frame detection on the half-rate strobe
  assign rateStrobe   = slaveMode & divTick & divLevel;
  assign txFrameInt   = pinFilt_r[spi_clkstop_pkg::PIN_TXFS] ^ txFramePolarity;
  assign rxFrameInt   = pinFilt_r[spi_clkstop_pkg::PIN_RXFS] ^ rxFramePolarity;
  assign slvClkChange = rateStrobe & (pinFilt_r[spi_clkstop_pkg::PIN_SCLK] != slvClk_r);
  assign slvClkRise   = pinFilt_r[spi_clkstop_pkg::PIN_SCLK];
  assign sActEdge     = slvClkChange & (slvClkRise == activeLevel) & slvTxFrame_r;
  assign sIdleEdge    = slvClkChange & (slvClkRise == idleLevel) & slvTxFrame_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slvClk_r     <= 1'b0;
      slvTxFrame_r <= 1'b0;
      slvRxFrame_r <= 1'b0;
    end else if (rateStrobe) begin
      slvClk_r     <= pinFilt_r[spi_clkstop_pkg::PIN_SCLK];
      slvTxFrame_r <= txFrameInt;
      slvRxFrame_r <= rxFrameInt;
    end else if (!slaveMode) begin
      slvTxFrame_r <= 1'b0;
      slvRxFrame_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // common bit engine
  assign frameOn    = masterMode ? masterFrame : slvTxFrame_r;
  assign frameStart = frameOn & ~frameOn_r;
  assign frameEnd   = ~frameOn & frameOn_r;
  assign rxFrameOk  = masterMode | slvRxFrame_r;
  assign activeEdge = masterMode ? mActEdge : sActEdge;
  assign idleEdge   = masterMode ? mIdleEdge : sIdleEdge;
  // mode 11 samples on the active edge, mode 10 on the idle edge
  assign sampleEdge = (halfDelay ? activeEdge : idleEdge) & rxFrameOk;
  assign changeEdge = halfDelay ? idleEdge : activeEdge;
  assign bitsFull   = (bitCnt_r == spi_clkstop_pkg::BITS_FULL);
  // rx data reaches us through the synchroniser, so a fast divider costs margin
  assign rxBit      = pinFilt_r[spi_clkstop_pkg::PIN_RXD];
  assign holdTake   = txValid & txReady;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txHold_r     <= '0;
      txHoldFull_r <= 1'b0;
    end else if (holdTake) begin
      txHold_r     <= txData;
      txHoldFull_r <= 1'b1;
    end else if (frameStart | ~stopOn) begin
      txHoldFull_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frameOn_r   <= 1'b0;
      txShift_r   <= '0;
      pendShift_r <= 1'b0;
      txDone_r    <= 1'b0;
    end else begin
      frameOn_r <= frameOn;
      if (frameStart) begin
        txShift_r   <= txHold_r;
        pendShift_r <= 1'b0;
        txDone_r    <= 1'b0;
      end else if (changeEdge & pendShift_r) begin
        pendShift_r <= 1'b0;
        if (bitsFull) begin
          txDone_r  <= 1'b1;
        end else begin
          txShift_r <= txShift_r << 1;
        end
      end else if (sampleEdge) begin
        pendShift_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxShift_r <= '0;
      bitCnt_r  <= '0;
      rxData_r  <= '0;
      rxValid_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      if (frameStart) begin
        bitCnt_r <= '0;
      end else if (sampleEdge & ~bitsFull) begin
        rxShift_r <= {rxShift_r[WB-2:0], rxBit};
        bitCnt_r  <= bitCnt_r + spi_clkstop_pkg::BIT_ONE;
      end
      if (frameEnd & bitsFull) begin
        rxData_r  <= rxShift_r;
        rxValid_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      configError_r <= 1'b0;
    end else begin
      configError_r <= stopOn & ~masterMode & ~slaveMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and user side
  assign txSerialClockPinOe  = masterMode;
  assign txSerialClockPinOut = (state_r == spi_clkstop_pkg::MS_SHIFT) ? divLevel
                                                                      : idleLevel;
  assign txFrameSyncPinOe    = masterMode;
  assign txFrameSyncPinOut   = masterFrame ^ txFramePolarity;
  assign txSerialDataPinOut  = txShift_r[WB-1];
  // a frame end always floats the line, which is the only release in mode 10
  assign txSerialDataPinOe   = frameOn & frameOn_r & ~txDone_r;
  assign txReady             = stopOn & ~txHoldFull_r;
  assign rxData              = rxData_r;
  assign rxValid             = rxValid_r;
  assign busy                = frameOn_r;
  assign configError         = configError_r;

endmodule // serial_port_spi_clock_stop

// ===== spi_clkstop_props.sv
// Purpose: pin and configuration checks for the clock-stop port
// Assumes: one clock domain, bound onto the top module
// Notes:   directions are decoded again here from the control ports
`timescale 1ns/100ps
module spi_clkstop_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [1:0] clockStopMode,
  input wire logic       txClockPolarity,
  input wire logic       rateClockSourceSel,
  input wire logic       txFramePolarity,
  input wire logic       txClockDirection,
  input wire logic       txFrameDirection,
  input wire logic       rxClockDirection,
  input wire logic       rxFrameDirection,
  input wire logic       busy,
  input wire logic       configError,
  input wire logic       txSerialClockPinOut,
  input wire logic       txSerialClockPinOe,
  input wire logic       txFrameSyncPinOut,
  input wire logic       txFrameSyncPinOe,
  input wire logic       txSerialDataPinOe
);
  wire logic [3:0] dirs   = {txClockDirection, txFrameDirection,
                             rxClockDirection, rxFrameDirection};
  wire logic       stopOn = clockStopMode[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // two cycles because the error flag is registered
  sequence s_badDirs;
    (stopOn && dirs != 4'hC && dirs != 4'h0) [*2];
  endsequence
  sequence s_slaveNoSrc;
    (stopOn && dirs == 4'h0 && !rateClockSourceSel) [*2];
  endsequence
  ////////////////////////////////////////////////////////////////
  a_master_drives_pins: assert property (
    stopOn && dirs == 4'hC |-> txSerialClockPinOe && txFrameSyncPinOe) else $error("pins undriven");
  a_slave_takes_pins: assert property (
    dirs == 4'h0 |-> !txSerialClockPinOe && !txFrameSyncPinOe) else $error("slave drives pins");
  a_bad_dirs_error: assert property (
    s_badDirs |-> configError && !txSerialClockPinOe && !txFrameSyncPinOe) else $error("bad dirs");
  a_slave_rate_src: assert property (
    s_slaveNoSrc |-> configError) else $error("slave rate source not flagged");
  a_enable_active_low: assert property (
    txSerialDataPinOe && txFrameSyncPinOe && txFramePolarity |-> !txFrameSyncPinOut)
    else $error("enable not low");
  a_data_floats_idle: assert property (
    !busy |-> !txSerialDataPinOe) else $error("data driven outside frame");
  a_lead_clock_idle: assert property (
    $fell(txFrameSyncPinOut) && txFrameSyncPinOe && txFramePolarity
    |-> txSerialClockPinOut == txClockPolarity) else $error("clock moved at enable");
  a_idle_clock_rest: assert property (
    txSerialClockPinOe && !busy && txFrameSyncPinOut == txFramePolarity && $stable(txClockPolarity)
    |-> txSerialClockPinOut == txClockPolarity) else $error("clock not idle");
endmodule // spi_clkstop_props
bind serial_port_spi_clock_stop spi_clkstop_props props (.clk, .rstn, .clockStopMode,
  .txClockPolarity, .rateClockSourceSel, .txFramePolarity, .txClockDirection,
  .txFrameDirection, .rxClockDirection, .rxFrameDirection, .busy, .configError,
  .txSerialClockPinOut, .txSerialClockPinOe, .txFrameSyncPinOut, .txFrameSyncPinOe,
  .txSerialDataPinOe);

// ===== spi_peer_slave.sv
// Purpose: behavioural slave peer on the serial data lines
// Assumes: master clock is slow against clk, edges seen one cycle late
// Notes:   deselected output shows the inverse bit so no stale bit can be read
`timescale 1ns/100ps
module spi_peer_slave (
  input  wire logic       clk,
  input  wire logic       sclk,
  input  wire logic       enableN,
  input  wire logic       cpol,
  input  wire logic       halfDelay,
  input  wire logic       mosi,
  input  wire logic [7:0] pattern,
  output logic            miso,
  output logic [7:0]      got
);
  logic       prevClk = 1'b0;
  logic       sampled = 1'b0;
  logic [2:0] idx     = 3'h0;
  wire logic  edgeSeen   = sclk !== prevClk;
  wire logic  activeEdge = edgeSeen && sclk !== cpol;
  wire logic  sampleEdge = halfDelay ? activeEdge : edgeSeen && !activeEdge;
  assign miso = enableN ? ~pattern[3'h7 - idx] : pattern[3'h7 - idx];
  always @(posedge clk) begin
    prevClk <= sclk;
    if (enableN) begin
      idx <= 3'h0;
      sampled <= 1'b0;
    end else if (sampleEdge) begin
      got <= {got[6:0], mosi};
      sampled <= 1'b1;
    end else if (edgeSeen && sampled)
      idx <= idx + 3'h1;
  end
endmodule // spi_peer_slave

// ===== tb_serial_port_spi_clock_stop.sv
// Purpose: self-checking bench, master frames against a slave peer
// Assumes: frame pins active low
// Notes:   receive checked only at slow dividers, input sync latency
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_port_spi_clock_stop;
  logic       clk = 1'b0, rstn = 1'b0, txValid = 1'b0, txClockPolarity = 1'b0, fs = 1'b1;
  logic       rateClockSourceSel = 1'b1, rxFramePolarity = 1'b1, txFramePolarity = 1'b1;
  logic [1:0] clockStopMode = 2'h0;
  logic [3:0] dirs = 4'hC;
  logic [7:0] rateClockDivider = 8'h01, txData = 8'h00, pat = 8'h00, rxData, peerGot, rxw;
  logic       txReady, rxValid, busy, configError, rxSerialDataPinIn, pc, pf, po;
  logic       txSerialClockPinOut, txSerialClockPinOe, txFrameSyncPinOut, txFrameSyncPinOe;
  logic       txSerialDataPinOut, txSerialDataPinOe;
  int         checked = 0, fails = 0, cyc = 0, fa, fd, df, n;
  int         tg[$];
  wire logic  mosiWire = txSerialDataPinOe ? txSerialDataPinOut : ~txSerialDataPinOut;
  initial forever #12.5 clk = ~clk;
  serial_port_spi_clock_stop dut (.clk, .rstn, .clockStopMode, .txClockPolarity,
    .rateClockSourceSel, .rateClockDivider, .rxFramePolarity, .txFramePolarity,
    .txClockDirection(dirs[3]), .txFrameDirection(dirs[2]), .rxClockDirection(dirs[1]),
    .rxFrameDirection(dirs[0]), .txData, .txValid, .txReady, .rxData, .rxValid, .busy,
    .configError, .txSerialClockPinIn(1'b1), .txSerialClockPinOut, .txSerialClockPinOe,
    .txFrameSyncPinIn(fs), .txFrameSyncPinOut, .txFrameSyncPinOe, .rxFrameSyncPinIn(fs),
    .rxSerialDataPinIn, .txSerialDataPinOut, .txSerialDataPinOe);
  spi_peer_slave peer (.clk, .sclk(txSerialClockPinOut), .enableN(txFrameSyncPinOut),
    .cpol(txClockPolarity), .halfDelay(clockStopMode[0]), .mosi(mosiWire), .pattern(pat),
    .miso(rxSerialDataPinIn), .got(peerGot));
  ////////////////////////////////////////////////////////////////
  // edge log in clk cycles, sampled once the edge's updates land
  always @(posedge clk) begin
    #1;
    cyc++;
    if (txSerialClockPinOut !== pc) tg.push_back(cyc);
    if (txFrameSyncPinOut === 1'b0 && pf === 1'b1) begin
      fa = cyc;
      tg = {};
    end
    if (txFrameSyncPinOut === 1'b1 && pf === 1'b0) fd = cyc;
    if (txSerialDataPinOe !== 1'b1 && po === 1'b1) df = cyc;
    if (rxValid === 1'b1) rxw = rxData;
    {pc, pf, po} = {txSerialClockPinOut, txFrameSyncPinOut, txSerialDataPinOe};
  end
  function automatic int ph(input int d, input logic hi);
    return (d == 0) ? 1 : (d % 2) ? (d + 1) / 2 : d / 2 + int'(hi);
  endfunction
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic guard(input int lim);
    if (n >= lim) begin
      fails++;
      close_out();
    end
  endtask
  task automatic cfg(input logic [3:0] dv, input logic src, input logic err);
    {dirs, rateClockSourceSel, clockStopMode} = {dv, src, 2'h2};
    repeat (2) @(negedge clk);
    `CHK("configError", err, configError)
    `CHK("clockOe", dv == 4'hC, txSerialClockPinOe)
  endtask
  task automatic frame(input logic [1:0] md, input logic pol, input int d, input logic rx);
    logic [7:0] w;
    int pd;
    w = 8'($urandom);
    pd = (d == 0) ? 2 : d + 1;
    @(negedge clk);
    {clockStopMode, txClockPolarity, rateClockDivider} = {md, pol, 8'(d)};
    {txData, txValid, pat, rxw} = {w, 1'b1, 8'($urandom), 8'hXX};
    for (n = 0; txReady !== 1'b1 && n < 40; n++) @(negedge clk);
    guard(40);
    @(negedge clk);
    txValid = 1'b0;
    for (n = 0; busy !== 1'b1 && n < 10; n++) @(negedge clk);
    guard(10);
    for (n = 0; (busy !== 1'b0 || (rx && $isunknown(rxw))) && n < 3000; n++) @(negedge clk);
    guard(3000);
    `CHK("edges", 16, tg.size())
    if (tg.size() == 16) begin
      `CHK("period", pd, tg[2] - tg[0])
      `CHK("active", ph(d, !pol), tg[1] - tg[0])
      `CHK("idle", ph(d, pol), tg[2] - tg[1])
      `CHK("lead", md[0] ? pd : ph(d, pol), tg[0] - fa)
      `CHK("trail", md[0] ? ph(d, pol) : pd, fd - tg[15])
      `CHK("release", 1'b1, (df - (md[0] ? tg[15] : fd)) inside {0, 1})
    end
    `CHK("mosi", w, peerGot)
    if (rx) `CHK("miso", pat, rxw)
    $display("frame mode %0d pol %0d div %0d done", md, pol, d);
  endtask
  initial begin
    n = $urandom(32'h78BA0EFB);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    cfg(4'h8, 1'b1, 1'b1);
    cfg(4'h0, 1'b0, 1'b1);
    cfg(4'h0, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      fs = k[0];
      repeat (12) @(negedge clk);
      `CHK("slaveFrame", {2{~k[0]}}, {busy, txSerialDataPinOe})
    end
    cfg(4'hC, 1'b1, 1'b0);
    $display("config checks done");
    frame(2'h3, 1'b0, 0, 1'b0);
    frame(2'h2, 1'b1, 1, 1'b0);
    frame(2'h3, 1'b1, 2, 1'b0);
    frame(2'h2, 1'b0, 4, 1'b0);
    repeat (8) frame(2'h2 + 2'($urandom_range(0, 1)), 1'($urandom), 11 + $urandom_range(0, 4), 1'b1);
    close_out();
  end
endmodule // tb_serial_port_spi_clock_stop
